/* testbench/scfg_mem_model.sv */
// Two memory banks behind the chip selects, counting their accesses
`timescale 1ns/10ps
module scfg_mem_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Selects from the block
	input  wire logic mreq,
	input  wire logic low_chip_select_n,
	input  wire logic upper_chip_select_n,
	// Access counts
	output logic [7:0] low_hits_q,
	output logic [7:0] upper_hits_q
);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			low_hits_q   <= 8'h00;
			upper_hits_q <= 8'h00;
		end else if (mreq) begin
			low_hits_q   <= low_hits_q + {7'h00, !low_chip_select_n};
			upper_hits_q <= upper_hits_q + {7'h00, !upper_chip_select_n};
		end
	end
endmodule : scfg_mem_model

/* testbench/scfg_sys_config_props.sv */
// Port checker for the system configuration block
`timescale 1ns/10ps
module scfg_sys_config_props
	import scfg_pkg::*;
(
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rstn,
	// Bus side
	input wire scfg_pkg::scfg_bus_t bus,
	input wire logic                rdata_valid,
	// Halt side
	input wire logic                halt_t4_low,
	input wire logic                nmi_n,
	input wire scfg_pkg::scfg_gates_t gates,
	input wire logic                halted,
	// Decode and reset pin
	input wire logic                low_chip_select_n,
	input wire logic                upper_chip_select_n,
	input wire logic                mem_wait_req,
	input wire logic [1:0]          mem_wait_count,
	input wire logic                reset_out_oe,
	input wire logic                reset_out_o
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	logic       mem_cyc;
	logic       io_rd;
	logic [4:0] oe_cnt_q;
	assign mem_cyc = bus.mreq && !bus.iorq;
	assign io_rd = bus.iorq && bus.rd && !bus.m1;

	// Length of the current reset pin drive
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			oe_cnt_q <= 5'h0;
		end else if (reset_out_oe) begin
			oe_cnt_q <= oe_cnt_q + 5'h1;
		end else begin
			oe_cnt_q <= 5'h0;
		end
	end

	a_decode_mem_only: assert property (
		!mem_cyc |-> low_chip_select_n && upper_chip_select_n && !mem_wait_req)
		else $error("decode active outside a memory cycle");
	a_selects_disjoint: assert property (
		low_chip_select_n || upper_chip_select_n)
		else $error("both chip selects active");
	a_wait_idle_zero: assert property (
		!mem_wait_req |-> mem_wait_count == 2'h0)
		else $error("wait count outside window");
	a_read_answer: assert property (
		io_rd && bus.addr[7:0] == SCFG_IO_DATA |=> rdata_valid)
		else $error("data port read not answered");
	a_valid_cause: assert property (
		rdata_valid |-> $past(io_rd))
		else $error("read valid without a read");
	a_pulse_len: assert property (
		$fell(reset_out_oe) |-> oe_cnt_q == 5'h10)
		else $error("reset pin drive not sixteen cycles");
	a_pulse_low: assert property (
		reset_out_oe |-> !reset_out_o)
		else $error("reset pin driven high");
	a_gate_sets: assert property (
		gates inside {7'h7F, 7'h40, 7'h62, 7'h00})
		else $error("illegal clock gate combination");
	a_run_no_halt: assert property (
		!halt_t4_low && !halted |-> gates == 7'h7F)
		else $error("clocks gated outside halt");
	a_halt_entry: assert property (
		!halted && halt_t4_low && !gates.cpu |=> halted)
		else $error("halted not set after gating");
	a_wake_bound: assert property (
		halted && !nmi_n && !halt_t4_low |-> ##[1:6] !halted)
		else $error("no wake after interrupt");
endmodule : scfg_sys_config_props

/* testbench/scfg_sys_config_tb.sv */
// Testbench for the system configuration block
`timescale 1ns/10ps
module scfg_sys_config_tb;
	import scfg_pkg::*;
	logic        ref_clk, rstn, halt_t4_low, nmi_n, int_n;
	logic        reset_pin_in_n, ext_clock_in_use, rdata_valid;
	logic        low_chip_select_n, upper_chip_select_n, mem_wait_req;
	logic        clk_div_bypass, crc32_enable, reset_out_oe, reset_out_o;
	logic        halted;
	logic [1:0]  mem_wait_count;
	logic [7:0]  rdata, low_hits_q, upper_hits_q, lh, uh;
	logic [6:0]  gate_tab [4];
	scfg_bus_t   bus;
	scfg_gates_t gates;
	int          fails, tests_run, cyc, n;

	always #12.5 ref_clk = ~ref_clk;

	scfg_sys_config u_dut (.ref_clk, .rstn, .bus, .rdata, .rdata_valid,
		.halt_t4_low, .nmi_n, .int_n, .reset_pin_in_n, .ext_clock_in_use,
		.low_chip_select_n, .upper_chip_select_n, .mem_wait_req,
		.mem_wait_count, .clk_div_bypass, .crc32_enable, .reset_out_oe,
		.reset_out_o, .gates, .halted);

	scfg_mem_model u_mem (.ref_clk, .rstn, .mreq(bus.mreq),
		.low_chip_select_n, .upper_chip_select_n, .low_hits_q,
		.upper_hits_q);

	task automatic print_verdict();
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Bus is held until the taking edge, then left for the next caller
	task automatic io(logic [7:0] a, logic wr, logic [7:0] d);
		bus = '{addr:{8'h00, a}, mreq:1'b0, iorq:1'b1, rd:!wr, wr:wr,
			m1:1'b0, wdata:d};
		@(posedge ref_clk);
		#2;
	endtask : io

	task automatic wreg(logic [7:0] idx, logic [7:0] d);
		io(SCFG_IO_PTR, 1'b1, idx);
		io(SCFG_IO_DATA, 1'b1, d);
	endtask : wreg

	task automatic rreg(logic [7:0] idx, logic [7:0] exp);
		io(SCFG_IO_PTR, 1'b1, idx);
		io(SCFG_IO_DATA, 1'b0, 8'h00);
		check("indirect read", rdata, exp);
	endtask : rreg

	// Expected: low select, upper select, wait request, wait count
	task automatic mem(logic [15:0] a, logic [4:0] exp);
		bus = '{addr:a, mreq:1'b1, iorq:1'b0, rd:1'b1, wr:1'b0, m1:1'b0,
			wdata:8'h00};
		#1 check("decode", {3'h0, low_chip_select_n, upper_chip_select_n,
			mem_wait_req, mem_wait_count}, {3'h0, exp});
		@(posedge ref_clk);
		#2;
	endtask : mem

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		ref_clk = 0;
		rstn = 0;
		bus = '0;
		halt_t4_low = 0;
		nmi_n = 1;
		int_n = 1;
		reset_pin_in_n = 1;
		ext_clock_in_use = 0;
		fails = 0;
		tests_run = 0;
		cyc = 0;
		gate_tab = '{7'h40, 7'h62, 7'h00, 7'h7F};
		repeat (6) @(posedge ref_clk);
		#2 rstn = 1;
		rreg(8'h01, 8'hF0);
		rreg(8'h03, 8'h01);
		io(SCFG_IO_PTR, 1'b1, 8'h02);
		io(SCFG_IO_DATA, 1'b0, 8'h00);
		check("cs window", {4'h0, rdata[3:0]}, 8'h0F);
		mem(16'hF000, 5'b01111);
		io(SCFG_IO_PTR, 1'b1, 8'h03);
		io(SCFG_IO_PTR, 1'b1, 8'h04);
		io(SCFG_IO_PTR, 1'b0, 8'h00);
		check("pointer", rdata, 8'h03);
		wreg(8'h02, 8'h73);
		wreg(8'h01, 8'h92);
		wreg(8'h03, 8'h03);
		wreg(8'h00, 8'h00);
		lh = low_hits_q;
		uh = upper_hits_q;
		for (n = 0; n < 16; n++) begin
			mem({n[3:0], 12'h000}, {!(n <= 3), !(n > 3 && n <= 7),
				n >= 2 && n <= 9, 2'h0});
		end
		check("low bank", low_hits_q - lh, 8'h04);
		check("upper bank", upper_hits_q - uh, 8'h04);
		wreg(8'h03, 8'h00);
		mem(16'h1000, 5'b11000);
		for (n = 0; n < 4; n++) begin
			wreg(8'h00, {4'h0, n[1:0], 2'h0});
			mem(16'h5000, {3'b111, n[1:0]});
		end
		wreg(8'h03, 8'hFC);
		rreg(8'h03, 8'h1C);
		check("options", {6'h0, clk_div_bypass, crc32_enable}, 8'h03);
		// Divider bypass must not act on an external clock input
		ext_clock_in_use = 1;
		wreg(8'h03, 8'h16);
		check("bypass ext", {7'h0, clk_div_bypass}, 8'h00);
		check("crc on", {7'h0, crc32_enable}, 8'h01);
		// Non-default options, so the pin reset has something to undo
		bus = '0;
		reset_pin_in_n = 0;
		repeat (2) @(posedge ref_clk);
		#2 reset_pin_in_n = 1;
		n = 0;
		repeat (30) begin
			@(posedge ref_clk);
			#1 n += reset_out_oe;
		end
		#1 check("reset drive", n[7:0], 8'h10);
		rreg(8'h01, 8'hF0);
		rreg(8'h03, 8'h01);
		for (n = 0; n < 4; n++) begin
			ext_clock_in_use = (n == 1 || n == 3);
			io(SCFG_IO_WDT_CMD, 1'b1, 8'hDB);
			io(SCFG_IO_WDT_MODE, 1'b1, {3'h7, n[1:0], 3'h3});
			io(SCFG_IO_WDT_MODE, 1'b0, 8'h00);
			check("halt field", {6'h0, rdata[4:3]}, {6'h0, n[1:0]});
			bus = '0;
			halt_t4_low = 1;
			#1 check("gates", {1'h0, gates}, {1'h0, gate_tab[n]});
			@(posedge ref_clk);
			#2 halt_t4_low = 0;
			check("halted", {7'h0, halted}, {7'h0, n != 3});
			// Odd modes wake on the maskable line, even ones on the other
			nmi_n = n[0];
			int_n = !n[0];
			repeat (5) @(posedge ref_clk);
			#2 nmi_n = 1;
			int_n = 1;
			check("woken", {halted, gates}, 8'h7F);
		end
		io(SCFG_IO_WDT_CMD, 1'b1, 8'h4E);
		io(SCFG_IO_WDT_MODE, 1'b1, 8'hE3);
		io(SCFG_IO_WDT_MODE, 1'b0, 8'h00);
		check("halt field", {6'h0, rdata[4:3]}, 8'h03);
		print_verdict();
	end
endmodule : scfg_sys_config_tb

bind scfg_sys_config scfg_sys_config_props u_props (.ref_clk, .rstn, .bus,
	.rdata_valid, .halt_t4_low, .nmi_n, .gates, .halted,
	.low_chip_select_n, .upper_chip_select_n, .mem_wait_req,
	.mem_wait_count, .reset_out_oe, .reset_out_o);

/* verilog/scfg_pkg.sv */
// Package: constants and carriers for the system configuration block
package scfg_pkg;

	// ****************************************
	// I/O port addresses
	// ****************************************
	localparam logic [7:0] SCFG_IO_WDT_MODE  = 8'hF0;
	localparam logic [7:0] SCFG_IO_WDT_CMD   = 8'hF1;
	localparam logic [7:0] SCFG_IO_PTR       = 8'hEE;
	localparam logic [7:0] SCFG_IO_DATA      = 8'hEF;

	// ****************************************
	// Indirect register indices
	// ****************************************
	localparam logic [1:0] SCFG_IDX_WAIT_CFG = 2'h0;
	localparam logic [1:0] SCFG_IDX_MEM_WIN  = 2'h1;
	localparam logic [1:0] SCFG_IDX_CS_WIN   = 2'h2;
	localparam logic [1:0] SCFG_IDX_MISC     = 2'h3;
	localparam logic [7:0] SCFG_PTR_MAX      = 8'h03;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] SCFG_RST_WAIT_CFG = 8'hFF;
	localparam logic [7:0] SCFG_RST_MEM_WIN  = 8'hF0;
	localparam logic [7:0] SCFG_RST_CS_WIN   = 8'h0F;
	localparam logic [7:0] SCFG_RST_MISC     = 8'h01;
	localparam logic [7:0] SCFG_RST_WDT_MODE = 8'hFB;
	localparam logic [7:0] SCFG_RST_PTR      = 8'h00;

	// ****************************************
	// Field positions and codes
	// ****************************************
	localparam int         SCFG_MISC_DIV1    = 4;
	localparam int         SCFG_MISC_RSTDIS  = 3;
	localparam int         SCFG_MISC_CRC32   = 2;
	localparam int         SCFG_MISC_UCS_EN  = 1;
	localparam int         SCFG_MISC_LCS_EN  = 0;
	localparam logic [7:0] SCFG_MISC_MASK    = 8'h1F;
	localparam int         SCFG_WDT_HALT_LO  = 3;
	localparam logic [2:0] SCFG_WDT_RSVD     = 3'h3;
	localparam logic [7:0] SCFG_CMD_HALT_KEY = 8'hDB;
	localparam int         SCFG_MEMW_LO      = 2;
	localparam int         SCFG_M1_AUTO_CNT  = 16;

	// ****************************************
	// Timing
	// ****************************************
	localparam int         SCFG_RSTOUT_CLKS  = 16;

	// Halt power field encodings
	typedef enum logic [1:0] {
		SCFG_HM_IDLE_ALL   = 2'b00,
		SCFG_HM_IDLE_TIMER = 2'b01,
		SCFG_HM_STOP       = 2'b10,
		SCFG_HM_RUN        = 2'b11
	} scfg_halt_mode_t;

	// CPU bus cycle as seen by the block
	typedef struct packed {
		logic [15:0] addr;
		logic        mreq;
		logic        iorq;
		logic        rd;
		logic        wr;
		logic        m1;
		logic [7:0]  wdata;
	} scfg_bus_t;

	// Clock gate enables toward the units
	typedef struct packed {
		logic osc;
		logic clk_out;
		logic cpu;
		logic parallel;
		logic serial;
		logic timer;
		logic watchdog;
	} scfg_gates_t;

endpackage : scfg_pkg

/* verilog/scfg_reset_stretch.sv */
// Reset output stretcher: a fixed pulse after reset input falls
`timescale 1ns/10ps
module scfg_reset_stretch #(
	parameter int CLKS = 16
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Control
	input  wire logic trig,
	input  wire logic disable_out,
	// Pin drive
	output logic      rst_out_oe
);
	localparam int CW = $clog2(CLKS + 1);
	logic [CW-1:0] cnt_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (trig && !disable_out) begin
			cnt_q <= CW'(CLKS);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign rst_out_oe = (cnt_q != '0);

endmodule : scfg_reset_stretch

/* verilog/scfg_sys_config.sv */
// System configuration: indirect registers, decode, halt clock gating
`timescale 1ns/10ps

// Summary of operation
// - Wait window applies when A15..A12 lie between low and high nibbles.
// - Inside the window, wait count equals the memory wait field.
// - Power-on sets wait window to F0, covering all of memory.
// - Low select asserts when A15..A12 at most low nibble and enabled.
// - Upper select asserts above low nibble up to high nibble.
// - Chip-select window low nibble resets to all ones.
// - Misc bit 1 enables upper select; clear holds it high; resets 0.
// - Misc bit 0 enables low select; resets set.
// - Misc bit 4 bypasses divide-by-two unless clock input pin used.
// - Misc bit 3 clear: drive 16-clock reset pulse out on reset pin.
// - Misc bit 2 selects 32-bit CRC on serial channel A.
// - Power mode acts at halt; reset or interrupt exits it.
// - Halt field bits 4..3: 11 run, 00 idle_all_stopped, 01 idle_timer_running, 10 stop.
// - Halt field changes only after key DB written to command register.
// - Run mode keeps all units and clock output running.
// - Idle_all_stopped: oscillator runs; clock output and unit clocks stop.
// - Idle_timer_running: oscillator, timer, clock output run; others stop.
// - Stop: oscillator, clock output and all unit clocks stop.
// - Memory wait field bits 3..2 encode zero to three waits.
// - Registers reached by pointer port then data port.
// - Reset pin returns all these registers to defaults.
module scfg_sys_config
	import scfg_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	// CPU bus, same clock domain
	input  wire scfg_pkg::scfg_bus_t bus,
	output logic [7:0]               rdata,
	output logic                     rdata_valid,
	// Halt and wake
	input  wire logic                halt_t4_low,
	input  wire logic                nmi_n,
	input  wire logic                int_n,
	input  wire logic                reset_pin_in_n,
	input  wire logic                ext_clock_in_use,
	// Decode results
	output logic                     low_chip_select_n,
	output logic                     upper_chip_select_n,
	output logic                     mem_wait_req,
	output logic [1:0]               mem_wait_count,
	// Options
	output logic                     clk_div_bypass,
	output logic                     crc32_enable,
	output logic                     reset_out_oe,
	output logic                     reset_out_o,
	// Clock gates
	output scfg_pkg::scfg_gates_t    gates,
	output logic                     halted
);
	import scfg_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]      wait_configuration_q;
	logic [7:0]      memory_wait_window_q;
	logic [7:0]      chip_select_window_q;
	logic [7:0]      misc_options_q;
	logic [7:0]      config_pointer_q;
	scfg_halt_mode_t halt_power_field_q;
	logic            halt_key_q;
	logic            wait_prog_q;
	logic [4:0]      m1_cnt_q;
	logic            halted_q;
	logic [1:0]      nmi_sync_q;
	logic [1:0]      int_sync_q;
	logic [1:0]      rpin_sync_q;
	logic            rpin_prev_q;
	logic [7:0]      rdata_q;
	logic            rdata_valid_q;

	logic io_wr;
	logic io_rd;
	logic mem_cycle;
	logic [3:0] nib;
	logic wake;
	logic rpin_fall;

	// Window decoding used by the wait logic; the selects compare directly
	function automatic logic in_range(input logic [3:0] a,
		input logic [3:0] lo, input logic [3:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	assign io_wr = bus.iorq && bus.wr && !bus.m1;
	assign io_rd = bus.iorq && bus.rd && !bus.m1;
	assign mem_cycle = bus.mreq && !bus.iorq;
	assign nib = bus.addr[15:12];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_sync_q  <= 2'b11;
			int_sync_q  <= 2'b11;
			rpin_sync_q <= 2'b11;
			rpin_prev_q <= 1'b1;
		end else begin
			nmi_sync_q  <= {nmi_sync_q[0], nmi_n};
			int_sync_q  <= {int_sync_q[0], int_n};
			rpin_sync_q <= {rpin_sync_q[0], reset_pin_in_n};
			rpin_prev_q <= rpin_sync_q[1];
		end
	end
	assign rpin_fall = rpin_prev_q && !rpin_sync_q[1];

	// ****************************************
	// Indirect register access
	// ****************************************
	// Pointer port holds index
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			config_pointer_q <= SCFG_RST_PTR;
		end else if (rpin_fall) begin
			config_pointer_q <= SCFG_RST_PTR;
		end else if (io_wr && bus.addr[7:0] == SCFG_IO_PTR
			&& bus.wdata <= SCFG_PTR_MAX) begin
			config_pointer_q <= bus.wdata;
		end
	end

	logic data_wr;
	assign data_wr = io_wr && bus.addr[7:0] == SCFG_IO_DATA;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			memory_wait_window_q <= SCFG_RST_MEM_WIN;
			chip_select_window_q <= SCFG_RST_CS_WIN;
			misc_options_q       <= SCFG_RST_MISC;
		end else if (rpin_fall) begin
			memory_wait_window_q <= SCFG_RST_MEM_WIN;
			chip_select_window_q <= SCFG_RST_CS_WIN;
			misc_options_q       <= SCFG_RST_MISC;
		end else if (data_wr) begin
			unique case (config_pointer_q[1:0])
				SCFG_IDX_MEM_WIN: memory_wait_window_q <= bus.wdata;
				SCFG_IDX_CS_WIN:  chip_select_window_q <= bus.wdata;
				SCFG_IDX_MISC:
					misc_options_q <= bus.wdata & SCFG_MISC_MASK;
				SCFG_IDX_WAIT_CFG: ;
			endcase
		end
	end

	// Wait configuration: all ones until sixteen opcode fetches pass,
	// then cleared unless software wrote it first
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_configuration_q <= SCFG_RST_WAIT_CFG;
			wait_prog_q          <= 1'b0;
			m1_cnt_q             <= '0;
		end else if (rpin_fall) begin
			wait_configuration_q <= SCFG_RST_WAIT_CFG;
			wait_prog_q          <= 1'b0;
			m1_cnt_q             <= '0;
		end else if (data_wr && config_pointer_q[1:0] == SCFG_IDX_WAIT_CFG)
		begin
			wait_configuration_q <= bus.wdata;
			wait_prog_q          <= 1'b1;
		end else if (bus.m1 && bus.mreq && bus.rd
			&& m1_cnt_q < 5'(SCFG_M1_AUTO_CNT)) begin
			// Counts each fetch once on its first cycle would need an
			// edge; one count per fetch cycle strobe is assumed
			m1_cnt_q <= m1_cnt_q + 5'd1;
			if (m1_cnt_q == 5'(SCFG_M1_AUTO_CNT - 1) && !wait_prog_q) begin
				wait_configuration_q <= '0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			halt_key_q         <= 1'b0;
			halt_power_field_q <= SCFG_HM_RUN;
		end else if (rpin_fall) begin
			halt_key_q         <= 1'b0;
			halt_power_field_q <= SCFG_HM_RUN;
		end else if (io_wr && bus.addr[7:0] == SCFG_IO_WDT_CMD) begin
			halt_key_q <= (bus.wdata == SCFG_CMD_HALT_KEY);
		end else if (io_wr && bus.addr[7:0] == SCFG_IO_WDT_MODE) begin
			if (halt_key_q) begin
				halt_power_field_q <= scfg_halt_mode_t'(
					bus.wdata[SCFG_WDT_HALT_LO +: 2]);
			end
			halt_key_q <= 1'b0;
		end
	end

	// Read back; watchdog fields other than the halt mode live elsewhere
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q       <= '0;
			rdata_valid_q <= 1'b0;
		end else begin
			rdata_valid_q <= io_rd && (bus.addr[7:0] == SCFG_IO_PTR
				|| bus.addr[7:0] == SCFG_IO_DATA
				|| bus.addr[7:0] == SCFG_IO_WDT_MODE);
			if (io_rd) begin
				unique case (bus.addr[7:0])
					SCFG_IO_PTR:  rdata_q <= config_pointer_q;
					SCFG_IO_WDT_MODE:
						rdata_q <= {SCFG_RST_WDT_MODE[7:5],
							halt_power_field_q, SCFG_WDT_RSVD};
					SCFG_IO_DATA: begin
						unique case (config_pointer_q[1:0])
							SCFG_IDX_WAIT_CFG: rdata_q <= wait_configuration_q;
							SCFG_IDX_MEM_WIN:  rdata_q <= memory_wait_window_q;
							SCFG_IDX_CS_WIN:   rdata_q <= chip_select_window_q;
							SCFG_IDX_MISC:     rdata_q <= misc_options_q;
						endcase
					end
					default: rdata_q <= '0;
				endcase
			end
		end
	end
	assign rdata       = rdata_q;
	assign rdata_valid = rdata_valid_q;

	// ****************************************
	// Address decode
	// ****************************************
	// Wait window compare
	assign mem_wait_req = mem_cycle && in_range(nib,
		memory_wait_window_q[3:0], memory_wait_window_q[7:4]);
	assign mem_wait_count = mem_wait_req ?
		wait_configuration_q[SCFG_MEMW_LO +: 2] : 2'b00;

	assign low_chip_select_n = !(mem_cycle
		&& misc_options_q[SCFG_MISC_LCS_EN]
		&& nib <= chip_select_window_q[3:0]);
	assign upper_chip_select_n = !(mem_cycle
		&& misc_options_q[SCFG_MISC_UCS_EN]
		&& nib > chip_select_window_q[3:0]
		&& nib <= chip_select_window_q[7:4]);

	// ****************************************
	// Options
	// ****************************************
	// Bypass only on crystal path
	assign clk_div_bypass = misc_options_q[SCFG_MISC_DIV1]
		&& !ext_clock_in_use;
	assign crc32_enable = misc_options_q[SCFG_MISC_CRC32];
	assign reset_out_o  = 1'b0;

	scfg_reset_stretch #(
		.CLKS        (SCFG_RSTOUT_CLKS)
	) u_rst_stretch (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.trig        (rpin_fall),
		.disable_out (misc_options_q[SCFG_MISC_RSTDIS]),
		.rst_out_oe  (reset_out_oe)
	);

	// ****************************************
	// Halt power modes
	// ****************************************
	assign wake = !nmi_sync_q[1] || !int_sync_q[1] || rpin_fall;

	// Enter at halt, leave on wake
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			halted_q <= 1'b0;
		end else if (wake) begin
			halted_q <= 1'b0;
		end else if (halt_t4_low && halt_power_field_q != SCFG_HM_RUN) begin
			halted_q <= 1'b1;
		end
	end
	assign halted = halted_q;

	// Gates are combinational so clocks stop in the T4 low cycle itself
	always_comb begin
		logic stop_now;
		stop_now = halted_q || (halt_t4_low && !wake);
		gates = '1;
		if (stop_now) begin
			unique case (halt_power_field_q)
				SCFG_HM_RUN: gates = '1;
				SCFG_HM_IDLE_ALL: begin
					gates     = '0;
					gates.osc = 1'b1;
				end
				SCFG_HM_IDLE_TIMER: begin
					gates         = '0;
					gates.osc     = 1'b1;
					gates.clk_out = 1'b1;
					gates.timer   = 1'b1;
				end
				SCFG_HM_STOP: gates = '0;
			endcase
		end
	end

endmodule : scfg_sys_config
